// ### rtl/smps_pkg.sv
// package: constants and types of the sync memory port sequencer
package smps_pkg;
  localparam int ADDR_W     = 20;
  localparam int DATA_W     = 32;
  localparam int BE_W       = 4;
  localparam int SD_CAS_LAT = 3;
  localparam int PDT_FLUSH  = 3;
  localparam int SD_AP_BIT  = 10;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] RST_ADDR = 20'h0_0000;
  // {row, column, write} strobe codes, active low
  localparam logic [2:0] SD_READ  = 3'h5;
  localparam logic [2:0] SD_WRITE = 3'h4;
  localparam logic [2:0] SD_PRE   = 3'h2;
  localparam logic [2:0] SD_MRS   = 3'h0;
  localparam logic [2:0] SD_SREF  = 3'h1;
  typedef enum logic [3:0] {
    C_SYNC_RD  = 4'h0,
    C_SYNC_WR  = 4'h1,
    C_SD_RD    = 4'h2,
    C_SD_WR    = 4'h3,
    C_SD_PREA  = 4'h4,
    C_SD_DEACTIVATE_BANK  = 4'h5,
    C_SD_MRS   = 4'h6,
    C_SREF_IN  = 4'h7,
    C_SREF_OUT = 4'h8
  } smps_cmd_e;
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_CMD   = 3'h1,
    S_WAIT  = 3'h3,
    S_DATA  = 3'h2,
    S_DESEL = 3'h6,
    S_END   = 3'h7,
    S_ACK   = 3'h5
  } smps_state_e;
endpackage : smps_pkg

// ### rtl/smps_sync2.sv
// module: two flip-flop level synchroniser
module smps_sync2 import smps_pkg::*; (
  // clock
  input  wire logic clk,
  // level
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    meta_q <= d;
    q      <= meta_q;
  end
endmodule : smps_sync2

// ### rtl/smps_delay.sv
// module: stepped delay line with selectable tap 0..3
module smps_delay import smps_pkg::*; (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control
  input  wire logic       step,
  input  wire logic [1:0] sel,
  // pulse
  input  wire logic       din,
  output logic            dout
);
  logic [2:0] line_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      line_q <= 3'h0;
      dout   <= 1'b0;
    end else if (step) begin
      line_q <= {line_q[1:0], din};
      dout   <= (sel == 2'h0) ? din : line_q[sel - 2'h1];
    end
  end
endmodule : smps_delay

// ### rtl/smps_port.sv
// module: memory port sequencer top
module smps_port import smps_pkg::*; (
  // clocks and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              link_clk,
  // request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire smps_cmd_e         req_cmd,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [BE_W-1:0]   req_be,
  input  wire logic              source_direct_flag,
  input  wire logic              dest_direct_flag,
  // answer
  output logic                   done,
  output logic [DATA_W-1:0]      rd_data,
  // configuration
  input  wire logic [1:0]        sync_read_latency,
  input  wire logic [1:0]        sync_write_latency,
  input  wire logic              select_extend,
  input  wire logic              strobe_function_select,
  input  wire logic              sync_clock_select,
  input  wire logic [1:0]        direct_read_latency,
  input  wire logic [1:0]        direct_write_latency,
  // memory clocks
  output logic                   memory_clock_out_a,
  output logic                   memory_clock_out_b,
  // memory pins
  output logic                   space_select_n,
  output logic                   strobe0_n,
  output logic                   strobe1_n,
  output logic                   strobe2_n,
  output logic                   dram_clock_enable,
  output logic                   peripheral_transfer_signal,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [BE_W-1:0]        mem_be_n,
  output logic [DATA_W-1:0]      mem_data_o,
  output logic                   mem_data_oe,
  input  wire logic [DATA_W-1:0] mem_data_i
);
  // system side bundle, stable while req_q is high
  logic              busy_q;
  logic              req_q;
  logic              done_q;
  logic [DATA_W-1:0] rd_data_q;
  smps_cmd_e         b_cmd_q;
  logic [ADDR_W-1:0] b_addr_q;
  logic [DATA_W-1:0] b_wdata_q;
  logic [BE_W-1:0]   b_be_q;
  logic              b_src_q;
  logic              b_dst_q;
  logic [1:0]        b_rl_q;
  logic [1:0]        b_wl_q;
  logic              b_ext_q;
  logic              b_fn_q;
  logic              b_csel_q;
  logic [1:0]        b_drl_q;
  logic [1:0]        b_dwl_q;
  logic              ack_s;
  // link side
  logic              link_rst;
  logic              req_s;
  smps_state_e       st_q;
  smps_state_e       st_d;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic              ack_q;
  logic              sref_q;
  logic              sref_d;
  logic              clkb_q;
  logic              adv;
  logic              dph_q;
  logic              dph_d;
  logic [DATA_W-1:0] rdata_q;
  logic              has_data;
  logic              is_rd;
  logic              is_wr;
  logic              is_sync;
  logic              direct;
  logic [1:0]        lat;
  smps_state_e       post;
  logic              oe_act;
  logic              sel_n_d;
  logic              s0_d;
  logic              s1_d;
  logic              s2_d;
  logic [ADDR_W-1:0] addr_d;
  logic              pdt_in;
  logic [2:0]        since_q;
  logic [2:0]        since_d;

  assign req_ready = !busy_q;
  assign done      = done_q;
  assign rd_data   = rd_data_q;

  // request accept and handshake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      req_q  <= 1'b0;
    end else if (req_valid && !busy_q) begin
      busy_q <= 1'b1;
      req_q  <= 1'b1;
    end else if (req_q && ack_s) begin
      req_q <= 1'b0;
    end else if (busy_q && !req_q && !ack_s) begin
      busy_q <= 1'b0;
    end
  end

  // bundle capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b_cmd_q   <= C_SYNC_RD;
      b_addr_q  <= RST_ADDR;
      b_wdata_q <= RST_DATA;
      b_be_q    <= 4'h0;
      b_src_q   <= 1'b0;
      b_dst_q   <= 1'b0;
      b_rl_q    <= 2'h0;
      b_wl_q    <= 2'h0;
      b_ext_q   <= 1'b0;
      b_fn_q    <= 1'b0;
      b_csel_q  <= 1'b0;
      b_drl_q   <= 2'h0;
      b_dwl_q   <= 2'h0;
    end else if (req_valid && !busy_q) begin
      b_cmd_q   <= req_cmd;
      b_addr_q  <= req_addr;
      b_wdata_q <= req_wdata;
      b_be_q    <= req_be;
      b_src_q   <= source_direct_flag;
      b_dst_q   <= dest_direct_flag;
      b_rl_q    <= sync_read_latency;
      b_wl_q    <= sync_write_latency;
      b_ext_q   <= select_extend;
      b_fn_q    <= strobe_function_select;
      b_csel_q  <= sync_clock_select;
      b_drl_q   <= direct_read_latency;
      b_dwl_q   <= direct_write_latency;
    end
  end

  // completion pulse and read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q    <= 1'b0;
      rd_data_q <= RST_DATA;
    end else begin
      done_q <= req_q && ack_s;
      if (req_q && ack_s) begin
        rd_data_q <= rdata_q;
      end
    end
  end

  smps_sync2 u_ack_sync (
    .clk (clk),
    .d   (ack_q),
    .q   (ack_s)
  );
  smps_sync2 u_rst_sync (
    .clk (link_clk),
    .d   (sys_rst),
    .q   (link_rst)
  );
  smps_sync2 u_req_sync (
    .clk (link_clk),
    .d   (req_q),
    .q   (req_s)
  );

  // memory clocks, b runs at half rate
  assign memory_clock_out_a = link_clk;
  assign memory_clock_out_b = clkb_q;
  assign adv = !b_csel_q || !clkb_q;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      clkb_q <= 1'b0;
    end else begin
      clkb_q <= !clkb_q;
    end
  end

  // command decode
  always_comb begin
    is_rd    = (b_cmd_q == C_SYNC_RD) || (b_cmd_q == C_SD_RD);
    is_wr    = (b_cmd_q == C_SYNC_WR) || (b_cmd_q == C_SD_WR);
    is_sync  = (b_cmd_q == C_SYNC_RD) || (b_cmd_q == C_SYNC_WR);
    has_data = is_rd || is_wr;
    direct   = (is_rd && b_src_q) || (is_wr && b_dst_q);
    post     = (is_sync && !b_fn_q) ? S_DESEL : S_END;
    unique case (b_cmd_q)
      C_SYNC_RD: lat = b_rl_q;
      C_SYNC_WR: lat = b_wl_q;
      C_SD_RD:   lat = 2'(SD_CAS_LAT);
      default:   lat = 2'h0;
    endcase
  end

  // sequencer
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      S_IDLE: begin
        if (req_s && !ack_q) begin
          st_d = S_CMD;
        end
      end
      S_CMD: begin
        cnt_d = 2'h0;
        if (!has_data) begin
          st_d = S_END;
        end else if (lat == 2'h0) begin
          st_d = post;
        end else if (lat == 2'h1) begin
          st_d = S_DATA;
        end else begin
          st_d  = S_WAIT;
          cnt_d = lat - 2'h2;
        end
      end
      S_WAIT: begin
        if (cnt_q == 2'h0) begin
          st_d = S_DATA;
        end else begin
          cnt_d = cnt_q - 2'h1;
        end
      end
      S_DATA: begin
        st_d  = post;
        cnt_d = 2'h0;
      end
      S_DESEL: begin
        st_d  = S_END;
        cnt_d = 2'h0;
      end
      S_END: begin
        if (cnt_q == 2'(PDT_FLUSH)) begin
          st_d = S_ACK;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      S_ACK: begin
        if (!req_s) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d  = S_IDLE;
        cnt_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      st_q  <= S_IDLE;
      cnt_q <= 2'h0;
      ack_q <= 1'b0;
    end else if (adv) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      ack_q <= (st_d == S_ACK);
    end
  end

  // pin values for the coming memory cycle
  always_comb begin
    dph_d   = has_data && ((st_d == S_DATA) || ((st_d == S_CMD) && (lat == 2'h0)));
    oe_act  = (b_cmd_q == C_SYNC_RD) && ((st_d == S_CMD) || (st_d == S_WAIT) || (st_d == S_DATA));
    sel_n_d = !((st_d == S_CMD) || (b_ext_q && oe_act));
    s0_d    = 1'b1;
    s1_d    = 1'b1;
    s2_d    = 1'b1;
    addr_d  = mem_addr;
    sref_d  = sref_q;
    if (st_d == S_CMD) begin
      addr_d = b_addr_q;
      unique case (b_cmd_q)
        C_SYNC_RD: s0_d = 1'b0;
        C_SYNC_WR: begin
          s0_d = 1'b0;
          s2_d = 1'b0;
        end
        C_SD_RD: {s1_d, s0_d, s2_d} = SD_READ;
        C_SD_WR: {s1_d, s0_d, s2_d} = SD_WRITE;
        C_SD_PREA: begin
          {s1_d, s0_d, s2_d} = SD_PRE;
          addr_d[SD_AP_BIT]  = 1'b1;
        end
        C_SD_DEACTIVATE_BANK: begin
          {s1_d, s0_d, s2_d} = SD_PRE;
          addr_d[SD_AP_BIT]  = 1'b0;
        end
        C_SD_MRS: {s1_d, s0_d, s2_d} = SD_MRS;
        C_SREF_IN: begin
          {s1_d, s0_d, s2_d} = SD_SREF;
          sref_d = 1'b1;
        end
        C_SREF_OUT: sref_d = 1'b0;
        default: sref_d = sref_q;
      endcase
    end
    if (oe_act) begin
      s1_d = 1'b0;
    end
    if (st_d == S_DESEL) begin
      s0_d = 1'b0;
    end
    pdt_in = dph_d && direct;
  end

  // registered pins, moved only on selected clock edges
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      space_select_n    <= 1'b1;
      strobe0_n         <= 1'b1;
      strobe1_n         <= 1'b1;
      strobe2_n         <= 1'b1;
      sref_q            <= 1'b0;
      dram_clock_enable <= 1'b1;
      mem_addr          <= RST_ADDR;
      mem_be_n          <= 4'hF;
      mem_data_o        <= RST_DATA;
      mem_data_oe       <= 1'b0;
      dph_q             <= 1'b0;
    end else if (adv) begin
      space_select_n    <= sel_n_d;
      strobe0_n         <= s0_d;
      strobe1_n         <= s1_d;
      strobe2_n         <= s2_d;
      sref_q            <= sref_d;
      dram_clock_enable <= !sref_d;
      mem_addr          <= addr_d;
      mem_be_n          <= ((st_d == S_CMD) || dph_d) ? ~b_be_q : 4'hF;
      if (st_d == S_CMD) begin
        mem_data_o <= b_wdata_q;
      end
      mem_data_oe       <= dph_d && is_wr && !direct;
      dph_q             <= dph_d;
    end
  end

  // read capture at end of data phase
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      rdata_q <= RST_DATA;
    end else if (adv && dph_q && is_rd && !direct) begin
      rdata_q <= mem_data_i;
    end
  end

  smps_delay u_pdt_delay (
    .clk  (link_clk),
    .rst  (link_rst),
    .step (adv),
    .sel  (is_rd ? b_drl_q : b_dwl_q),
    .din  (pdt_in),
    .dout (peripheral_transfer_signal)
  );

  // checking helper: memory cycles since command issue
  always_comb begin
    if (st_d == S_CMD) begin
      since_d = 3'h0;
    end else if (since_q == 3'h7) begin
      since_d = 3'h7;
    end else begin
      since_d = since_q + 3'h1;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      since_q <= 3'h0;
    end else if (adv) begin
      since_q <= since_d;
    end
  end

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (link_rst);

  sequence seq_data_start;
    adv && dph_d;
  endsequence

  chk_rd_latency: assert property (seq_data_start and (b_cmd_q == C_SYNC_RD) |-> since_d == {1'b0, b_rl_q})
    else $error("sync read latency wrong");
  chk_wr_latency: assert property (seq_data_start and (b_cmd_q == C_SYNC_WR) |-> since_d == {1'b0, b_wl_q})
    else $error("sync write latency wrong");
  chk_cas_latency: assert property (seq_data_start and (b_cmd_q == C_SD_RD) |-> since_d == 3'h3)
    else $error("sdram read latency not three");
  chk_select_drop: assert property (adv && !b_ext_q && (st_d != S_CMD) |=> space_select_n)
    else $error("select held past last command");
  chk_select_ext: assert property (b_ext_q && (b_cmd_q == C_SYNC_RD) && !strobe1_n |-> !space_select_n)
    else $error("select not held with output enable");
  chk_desel_mode: assert property ((st_q == S_DESEL) |-> !b_fn_q && is_sync)
    else $error("deselect cycle in wrong mode");
  chk_desel_seen: assert property (adv && (st_q == S_DATA) && is_sync && !b_fn_q |=> st_q == S_DESEL)
    else $error("deselect cycle missing");
  chk_pdt_direct: assert property (peripheral_transfer_signal |-> direct)
    else $error("transfer signal without direct transfer");
  chk_pdt_zero: assert property (direct && is_rd && (b_drl_q == 2'h0) && dph_q |-> peripheral_transfer_signal)
    else $error("direct read signal not aligned");
  chk_direct_hiz: assert property (direct && is_wr |-> !mem_data_oe)
    else $error("data driven on direct write");
  chk_direct_nocap: assert property (direct && is_rd |=> $stable(rdata_q))
    else $error("data captured on direct read");
  chk_sref_cke: assert property (sref_q |-> !dram_clock_enable)
    else $error("clock enable high in self refresh");
  chk_edge_only: assert property (!adv |=> $stable(space_select_n) && $stable(mem_addr) && $stable(strobe0_n))
    else $error("pin moved off selected clock edge");
endmodule : smps_port

// ### verif/smps_mem_model.sv
// memory model: answers reads on the port data inputs after the access latency
module smps_mem_model import smps_pkg::*; (
  // clocks
  input  wire logic              memory_clock_out_a,
  input  wire logic              memory_clock_out_b,
  input  wire logic              sync_clock_select,
  // pins
  input  wire logic              space_select_n,
  input  wire logic              strobe0_n,
  input  wire logic              strobe1_n,
  input  wire logic              strobe2_n,
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_data_i,
  // access kind
  input  wire logic              sdram,
  input  wire logic [1:0]        rd_lat
);
  timeunit 1ns;
  timeprecision 1ps;
  int                cnt;
  logic              pend;
  logic              drv;
  logic              rd;
  logic [2:0]        code;
  logic [ADDR_W-1:0] a;
  initial begin
    mem_data_i = 32'h0;
    pend = 1'b0;
    drv = 1'b0;
  end
  // data driven only in the data phase, inverted once released
  always @(posedge memory_clock_out_a) begin
    if (!sync_clock_select || !memory_clock_out_b) begin
      #1;
      code = {strobe1_n, strobe0_n, strobe2_n};
      rd = sdram ? code == SD_READ : !space_select_n && code == 3'h1;
      if (drv) begin
        mem_data_i = ~mem_data_i;
        drv = 1'b0;
      end
      if (pend)
        cnt = cnt - 1;
      if (rd) begin
        a = mem_addr;
        cnt = sdram ? SD_CAS_LAT : int'(rd_lat);
        pend = 1'b1;
      end
      if (pend && cnt == 0) begin
        mem_data_i = {12'hC3A, a};
        drv = 1'b1;
        pend = 1'b0;
      end
    end
  end
endmodule : smps_mem_model

// ### verif/tb_top.sv
// testbench: sequencer driven through every command kind
module tb_top import smps_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    smps_cmd_e cmd; logic [19:0] addr; logic [31:0] wd; logic [3:0] be; logic [1:0] lat;
    logic ext; logic fn; logic csel; logic dir; logic [1:0] dl; logic [2:0] code;
  } smps_row_s;
  logic clk, sys_rst, link_clk, req_valid, req_ready, done, cur_sd, cke_low;
  logic source_direct_flag, dest_direct_flag, select_extend, strobe_function_select, sync_clock_select;
  logic memory_clock_out_a, memory_clock_out_b, space_select_n, strobe0_n, strobe1_n, strobe2_n;
  logic dram_clock_enable, peripheral_transfer_signal, mem_data_oe;
  logic [1:0] sync_read_latency, sync_write_latency, direct_read_latency, direct_write_latency, cur_lat;
  smps_cmd_e req_cmd;
  logic [ADDR_W-1:0] req_addr, mem_addr, cap_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, mem_data_o, mem_data_i, cap_data, exp_rd, last_rd;
  logic [BE_W-1:0] req_be, mem_be_n, cap_be;
  logic [2:0] code;
  int failures, n_checks, cyc, t_cmd, t_pdt, t_oe, n_sel, n_desel, n_oe;
  smps_row_s r;
  smps_row_s rows [17] = '{
    '{C_SYNC_RD, 20'h00011, 32'h0, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h1},
    '{C_SYNC_RD, 20'h00022, 32'h0, 4'hF, 2'h1, 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 3'h1},
    '{C_SYNC_RD, 20'h00033, 32'h0, 4'hF, 2'h2, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h1},
    '{C_SYNC_RD, 20'h00044, 32'h0, 4'hF, 2'h3, 1'h1, 1'h0, 1'h1, 1'h0, 2'h0, 3'h1},
    '{C_SYNC_WR, 20'h00055, 32'h12345678, 4'h5, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h4},
    '{C_SYNC_WR, 20'h00066, 32'hA5A50F0F, 4'hF, 2'h3, 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 3'h4},
    '{C_SD_RD, 20'h00077, 32'h0, 4'hF, 2'h3, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h5},
    '{C_SD_RD, 20'h00088, 32'h0, 4'hF, 2'h3, 1'h0, 1'h0, 1'h0, 1'h1, 2'h0, 3'h5},
    '{C_SD_RD, 20'h00099, 32'h0, 4'hF, 2'h3, 1'h0, 1'h0, 1'h1, 1'h1, 2'h3, 3'h5},
    '{C_SD_WR, 20'h000AA, 32'hCAFE0001, 4'hA, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h4},
    '{C_SD_WR, 20'h000BB, 32'h0BADF00D, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 2'h1, 3'h4},
    '{C_SD_WR, 20'h000CC, 32'h55AA55AA, 4'hF, 2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 2'h2, 3'h4},
    '{C_SD_PREA, 20'h00000, 32'h0, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h2},
    '{C_SD_DEACTIVATE_BANK, 20'h00000, 32'h0, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h2},
    '{C_SD_MRS, 20'h00230, 32'h0, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h0},
    '{C_SREF_IN, 20'h00000, 32'h0, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h1},
    '{C_SREF_OUT, 20'h00000, 32'h0, 4'hF, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h7}};

  smps_port DUT (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .req_valid(req_valid), .req_ready(req_ready),
    .req_cmd(req_cmd), .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be),
    .source_direct_flag(source_direct_flag), .dest_direct_flag(dest_direct_flag), .done(done), .rd_data(rd_data),
    .sync_read_latency(sync_read_latency), .sync_write_latency(sync_write_latency), .select_extend(select_extend),
    .strobe_function_select(strobe_function_select), .sync_clock_select(sync_clock_select),
    .direct_read_latency(direct_read_latency), .direct_write_latency(direct_write_latency),
    .memory_clock_out_a(memory_clock_out_a), .memory_clock_out_b(memory_clock_out_b),
    .space_select_n(space_select_n), .strobe0_n(strobe0_n), .strobe1_n(strobe1_n), .strobe2_n(strobe2_n),
    .dram_clock_enable(dram_clock_enable), .peripheral_transfer_signal(peripheral_transfer_signal),
    .mem_addr(mem_addr), .mem_be_n(mem_be_n), .mem_data_o(mem_data_o), .mem_data_oe(mem_data_oe),
    .mem_data_i(mem_data_i));
  smps_mem_model mem (.memory_clock_out_a(memory_clock_out_a), .memory_clock_out_b(memory_clock_out_b),
    .sync_clock_select(sync_clock_select), .space_select_n(space_select_n), .strobe0_n(strobe0_n),
    .strobe1_n(strobe1_n), .strobe2_n(strobe2_n), .mem_addr(mem_addr), .mem_data_i(mem_data_i),
    .sdram(cur_sd), .rd_lat(cur_lat));

  always #50 clk = ~clk;
  initial begin
    link_clk = 1'h0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  // pin monitor, one sample per memory cycle
  always @(posedge memory_clock_out_a) begin
    if (!sys_rst && (!sync_clock_select || !memory_clock_out_b)) begin
      cyc++;
      if (space_select_n === 1'h0) begin
        n_sel++;
        if (t_cmd < 0) begin
          t_cmd = cyc;
          code = {strobe1_n, strobe0_n, strobe2_n};
          cap_addr = mem_addr;
        end
      end
      if (space_select_n === 1'h1 && strobe0_n === 1'h0)
        n_desel++;
      if (mem_data_oe === 1'h1) begin
        n_oe++;
        cap_data = mem_data_o;
        cap_be = mem_be_n;
        if (t_oe < 0)
          t_oe = cyc;
      end
      if (peripheral_transfer_signal === 1'h1 && t_pdt < 0)
        t_pdt = cyc;
      if (dram_clock_enable === 1'h0)
        cke_low = 1'h1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task automatic drive(input smps_row_s x);
    req_cmd = x.cmd;
    req_addr = x.addr;
    req_wdata = x.wd;
    req_be = x.be;
    sync_read_latency = x.cmd < C_SD_RD ? x.lat : 2'h1;
    sync_write_latency = sync_read_latency;
    select_extend = x.ext;
    strobe_function_select = x.fn;
    sync_clock_select = x.csel;
    source_direct_flag = x.dir && x.cmd == C_SD_RD;
    dest_direct_flag = x.dir && x.cmd == C_SD_WR;
    direct_read_latency = x.cmd == C_SD_WR ? ~x.dl : x.dl;
    direct_write_latency = x.cmd == C_SD_WR ? x.dl : ~x.dl;
    cur_lat = x.lat;
    cur_sd = x.cmd >= C_SD_RD;
    {t_cmd, t_pdt, t_oe, n_sel, n_desel, n_oe, cke_low} = {-32'sh1, -32'sh1, -32'sh1, 32'h0, 32'h0, 32'h0, 1'h0};
  endtask : drive

  task automatic run(input smps_row_s x);
    int k;
    @(negedge clk);
    for (k = 0; k < 400 && req_ready !== 1'h1; k++)
      @(negedge clk);
    if (k == 400) begin
      failures++;
      give_verdict();
    end
    drive(x);
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    chk(req_ready, 32'h0);
    for (k = 0; k < 400 && done !== 1'h1; k++)
      @(negedge clk);
    if (k == 400) begin
      failures++;
      give_verdict();
    end
  endtask : run

  task automatic reset_values();
    chk({space_select_n, strobe0_n, strobe1_n, strobe2_n, dram_clock_enable, peripheral_transfer_signal,
         mem_data_oe, req_ready, done}, 32'h1F2);
    chk({mem_be_n, mem_addr}, 32'hF00000);
    chk(rd_data, 32'h0);
  endtask : reset_values

  initial begin
    clk = 1'h0;
    sys_rst = 1'h1;
    req_valid = 1'h0;
    cyc = 0;
    last_rd = 32'h0;
    drive(rows[0]);
    repeat (4) @(negedge clk);
    reset_values();
    sys_rst = 1'h0;
    repeat (5) @(negedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      exp_rd = !r.dir ? {12'hC3A, r.addr} : last_rd;
      run(r);
      if (r.cmd != C_SREF_OUT) chk(code, r.code);
      if (r.cmd == C_SYNC_RD || r.cmd == C_SD_RD) begin
        chk(rd_data, exp_rd);
        last_rd = exp_rd;
      end
      if (r.cmd < C_SD_RD) begin
        chk(n_sel, r.cmd == C_SYNC_RD && r.ext ? r.lat + 32'h1 : 32'h1);
        chk(n_desel, !r.fn);
      end
      if ((r.cmd == C_SYNC_WR || r.cmd == C_SD_WR) && !r.dir) begin
        chk(t_oe - t_cmd, r.lat);
        chk(cap_data, r.wd);
        chk(cap_be, {28'h0, ~r.be});
      end
      if (r.cmd == C_SD_WR && r.dir) chk(n_oe, 32'h0);
      chk(t_pdt, r.dir ? t_cmd + r.lat + r.dl : -32'sh1);
      if (r.cmd == C_SD_PREA || r.cmd == C_SD_DEACTIVATE_BANK) chk(cap_addr[SD_AP_BIT], r.cmd == C_SD_PREA);
      if (r.cmd == C_SD_MRS) chk(cap_addr, r.addr);
      if (r.cmd == C_SREF_IN) chk(cke_low, 32'h1);
      if (r.cmd == C_SREF_OUT) chk(dram_clock_enable, 32'h1);
    end
    // reset in the middle of a long read, then recovery
    @(negedge clk);
    for (int j = 0; j < 400 && req_ready !== 1'h1; j++)
      @(negedge clk);
    drive(rows[3]);
    req_valid = 1'h1;
    @(negedge clk);
    req_valid = 1'h0;
    repeat (6) @(negedge clk);
    sys_rst = 1'h1;
    repeat (4) @(negedge clk);
    reset_values();
    sys_rst = 1'h0;
    repeat (5) @(negedge clk);
    run(rows[2]);
    chk(rd_data, {12'hC3A, rows[2].addr});
    give_verdict();
  end
endmodule : tb_top
